// *** bench/sdc_dma_checker.sv ***
// Assertions on the DMA controller ports
`timescale 1ns/1ns
`default_nettype none
module sdc_dma_checker #(
  parameter NCH  = 6,
  parameter NEVT = 14
) (
  // Clock and reset
  input wire logic            i_clk,
  input wire logic            i_srst,
  // Register port
  input wire logic [7:0]      i_reg_addr,
  input wire logic [15:0]     i_reg_wdata,
  input wire logic            i_reg_wr,
  input wire logic            i_reg_rd,
  input wire logic [15:0]     o_reg_rdata,
  input wire logic [NEVT-1:0] i_sync_evt,
  // Memory master
  input wire logic            o_mem_req,
  input wire logic            o_mem_we,
  input wire logic            o_mem_ext,
  input wire logic [1:0]      o_mem_space,
  input wire logic [15:0]     o_mem_addr,
  input wire logic [15:0]     o_mem_wdata,
  input wire logic [15:0]     i_mem_rdata,
  input wire logic            i_mem_ack,
  // CPU arbitration and events
  input wire logic            i_cpu_int_req,
  input wire logic            i_cpu_ext_req,
  input wire logic            i_cpu_ext_done,
  input wire logic            o_cpu_int_wait,
  input wire logic            o_cpu_ext_wait,
  input wire logic            o_cpu_ext_grant,
  input wire logic [NCH-1:0]  o_chan_evt
);
  logic       ext_rd;
  logic       ext_wr;
  logic [4:0] rd_len_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////
  assign ext_rd = o_mem_req && o_mem_ext && !o_mem_we;
  assign ext_wr = o_mem_req && o_mem_ext && o_mem_we;
  // Saturating external read length
  always @(posedge i_clk)
    if (i_srst)
      rd_len_r <= 5'h00;
    else
      rd_len_r <= ext_rd ? rd_len_r + {4'h0, ~&rd_len_r} : 5'h00;
  sequence s_int_rd;
    o_mem_req && !o_mem_we && !o_mem_ext && i_mem_ack;
  endsequence
  sequence s_wr_of_read;
    o_mem_req && o_mem_we && o_mem_wdata == $past(i_mem_rdata);
  endsequence
  ////////////////////////////////////////////////////////////
  a_rd_then_wr: assert property (s_int_rd |=> s_wr_of_read)
    else $error("read data not written");
  a_cpu_int_wait: assert property (o_cpu_int_wait == (i_cpu_int_req && o_mem_req && !o_mem_ext))
    else $error("internal wait mismatch");
  a_ext_rd_min: assert property ((rd_len_r != 5'h00 && !ext_rd) |-> rd_len_r >= 5'd11)
    else $error("external read too short");
  a_ext_wr_min: assert property ($rose(ext_wr) |-> ext_wr [*8])
    else $error("external write too short");
  a_ext_excl: assert property ((o_mem_req && o_mem_ext) |-> !o_cpu_ext_grant)
    else $error("bus granted to both owners");
  a_ext_wait_def: assert property (o_cpu_ext_wait == (i_cpu_ext_req && !o_cpu_ext_grant))
    else $error("external wait mismatch");
  a_cpu_keeps_bus: assert property ((o_cpu_ext_grant && !i_cpu_ext_done) |=> o_cpu_ext_grant)
    else $error("bus taken from cpu early");
  a_space_legal: assert property (o_mem_req |-> o_mem_space != 2'h3)
    else $error("reserved space driven");
  a_evt_pulse: assert property (o_chan_evt != 6'h00 |-> $onehot(o_chan_evt) ##1 o_chan_evt == 6'h00)
    else $error("event not a pulse");
  a_int_hold: assert property ((o_mem_req && !i_mem_ack && !o_mem_ext) |=> o_mem_req && $stable(o_mem_addr))
    else $error("access dropped before ack");
endmodule // sdc_dma_checker
bind sdc_dma sdc_dma_checker #(.NCH(NCH), .NEVT(NEVT)) u_chk (.*);
`default_nettype wire

// *** bench/sdc_dma_tb.sv ***
// Bench for the six-channel DMA controller
`timescale 1ns/1ns
`default_nettype none
module sdc_dma_tb;
  logic        i_clk, i_srst, i_reg_wr, i_reg_rd, slow;
  logic        i_cpu_int_req, i_cpu_ext_req, i_cpu_ext_done;
  logic [7:0]  i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata;
  logic [13:0] i_sync_evt;
  logic        o_mem_req, o_mem_we, o_mem_ext, i_mem_ack;
  logic        o_cpu_int_wait, o_cpu_ext_wait, o_cpu_ext_grant;
  logic [1:0]  o_mem_space;
  logic [5:0]  o_chan_evt;
  int          n_errors, n_tests;
  sdc_dma #(.NCH(6), .NEVT(14)) dut (.*);
  sdc_mem_model u_mem (.i_clk(i_clk), .i_slow(slow), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_reg_rdata, e);
  endtask
  task automatic cfg(input logic [3:0] ch, input logic [15:0] s, d, c, f, m);
    wr({ch, 4'h0}, s);
    wr({ch, 4'h1}, d);
    wr({ch, 4'h2}, c);
    wr({ch, 4'h3}, f);
    wr({ch, 4'h4}, m);
  endtask
  task automatic wevt(input int ch, input int n);
    int k = 0;
    for (int t = 0; t < 300 && k < n; t++)
    begin
      @(negedge i_clk);
      if (o_chan_evt[ch] === 1'b1)
        k++;
    end
    chk(16'(k), 16'(n));
  endtask
  task automatic quiet(input int len);
    int k = 0;
    repeat (len)
    begin
      @(negedge i_clk);
      if (o_mem_req === 1'b1)
        k++;
    end
    chk(16'(k), 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(8'h04, 16'h0000);
    wr(8'h04, 16'h0821);
    rd(8'h04, 16'h0821);
    wr(8'h84, 16'hFFFF);
    rd(8'h84, 16'h0000);
    wr(8'h04, 16'h0000);
  endtask
  task automatic t_basic;
    slow <= 1'b1;
    cfg(4'h0, 16'h0010, 16'h008F, 16'h0002, 16'h0000, 16'h4149);
    wr(8'h60, 16'h0001);
    wevt(0, 1);
    for (int i = 0; i < 3; i++)
      chk(u_mem.mem[8'h8F - i], 16'hD010 + 16'(i));
    rd(8'h00, 16'h0013);
    rd(8'h01, 16'h008C);
    rd(8'h60, 16'h0000);
    slow <= 1'b0;
  endtask
  task automatic t_index;
    logic [15:0] a;
    wr(8'h07, 16'h0001);
    wr(8'h61, 16'h0002);
    wr(8'h62, 16'h0005);
    wr(8'h63, 16'h0010);
    wr(8'h64, 16'h0030);
    cfg(4'h1, 16'h0020, 16'h00A0, 16'h0001, 16'h0001, 16'h6445);
    wr(8'h60, 16'h0002);
    wevt(1, 2);
    a = 16'h0020;
    for (int i = 0; i < 4; i++)
    begin
      chk(u_mem.mem[8'hA0 + i], 16'hD000 | a);
      a = a + ((i % 2) ? 16'h0010 : 16'h0002);
    end
    chk(u_mem.mem[8'hA4], 16'hD0A4);
    rd(8'h10, a);
    rd(8'h13, 16'h0000);
    wr(8'h07, 16'h0000);
  endtask
  task automatic t_dword;
    cfg(4'h2, 16'h0038, 16'h00F0, 16'h0000, 16'h0000, 16'h5145);
    wr(8'h60, 16'h0004);
    wevt(2, 1);
    chk(u_mem.mem[8'hF0], 16'hD038);
    chk(u_mem.mem[8'hF1], 16'hD039);
    rd(8'h20, 16'h003A);
  endtask
  task automatic t_auto;
    cfg(4'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    wr(8'h05, 16'h0060);
    wr(8'h06, 16'h00C0);
    wr(8'h25, 16'h0070);
    wr(8'h26, 16'h00D0);
    cfg(4'h2, 16'h0050, 16'h00B0, 16'h0000, 16'h0000, 16'hC145);
    wr(8'h60, 16'h0004);
    wevt(2, 2);
    wr(8'h60, 16'h8004);
    wevt(2, 2);
    wr(8'h60, 16'h0000);
    wevt(2, 1);
    chk(u_mem.mem[8'hB0], 16'hD050);
    chk(u_mem.mem[8'hC0], 16'hD060);
    chk(u_mem.mem[8'hD0], 16'hD070);
  endtask
  task automatic t_prio;
    logic [15:0] pv [3] = '{16'h0818, 16'h1018, 16'h0018};
    logic [15:0] ev [3] = '{16'h0003, 16'h0004, 16'h0004};
    int t;
    for (int r = 0; r < 3; r++)
    begin
      cfg(4'h3, 16'h0003, 16'h0093, 16'h0000, 16'h0000, 16'h4041);
      cfg(4'h4, 16'h0004, 16'h0094, 16'h0000, 16'h0000, 16'h4041);
      wr(8'h60, pv[r]);
      t = 0;
      while (o_mem_req !== 1'b1 && t < 50)
      begin
        @(negedge i_clk);
        t++;
      end
      chk(o_mem_addr, ev[r]);
      wevt((ev[r] == 16'h0003) ? 4 : 3, 1);
    end
  endtask
  task automatic t_sync;
    cfg(4'h5, 16'h0005, 16'h0095, 16'h0000, 16'hD000, 16'h4041);
    wr(8'h60, 16'h0020);
    quiet(20);
    i_sync_evt <= 14'h1000;
    @(posedge i_clk);
    i_sync_evt <= 14'h0000;
    wevt(5, 1);
  endtask
  task automatic t_ext;
    i_cpu_int_req <= 1'b1;
    i_cpu_ext_req <= 1'b1;
    cfg(4'h0, 16'h0030, 16'h00E0, 16'h0000, 16'h0000, 16'h4841);
    wr(8'h60, 16'h0001);
    quiet(12);
    chk(16'(o_cpu_ext_grant), 16'h0001);
    @(posedge i_clk);
    i_cpu_ext_done <= 1'b1;
    i_cpu_ext_req <= 1'b0;
    @(posedge i_clk);
    i_cpu_ext_done <= 1'b0;
    wevt(0, 1);
    chk(u_mem.mem[8'hE0], 16'hD030);
    cfg(4'h1, 16'h0031, 16'h00E1, 16'h0000, 16'h0000, 16'h4061);
    wr(8'h60, 16'h0002);
    @(posedge i_clk);
    i_cpu_ext_req <= 1'b1;
    wevt(1, 1);
    chk(u_mem.mem[8'hE1], 16'hD031);
    repeat (3) @(negedge i_clk);
    chk(16'(o_cpu_ext_grant), 16'h0001);
    @(posedge i_clk);
    i_cpu_ext_done <= 1'b1;
    i_cpu_ext_req <= 1'b0;
    i_cpu_int_req <= 1'b0;
    @(posedge i_clk);
    i_cpu_ext_done <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    final_report;
  end
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    i_srst = 1'b1;
    slow = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 16'h0000;
    i_sync_evt = 14'h0000;
    i_cpu_int_req = 1'b0;
    i_cpu_ext_req = 1'b0;
    i_cpu_ext_done = 1'b0;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    t_regs;
    t_basic;
    t_index;
    t_dword;
    t_auto;
    t_prio;
    t_sync;
    t_ext;
    final_report;
  end
endmodule // sdc_dma_tb
`default_nettype wire

// *** bench/sdc_mem_model.sv ***
// Memory model behind the DMA master port
`timescale 1ns/1ns
`default_nettype none
module sdc_mem_model (
  // Clock and mode
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  // Access from the DMA master
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] last_r;
  logic        held_r;
  ////////////////////////////////////////////////////////////
  // Slow mode delays each ack one cycle
  assign o_ack = i_req && (!i_slow || held_r);
  // Flat decode; idle data scrambled
  assign o_rdata = o_ack ? mem[i_addr[7:0]] : ~last_r;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 16'hD000 | 16'(i);
  end
  always @(posedge i_clk)
  begin
    held_r <= i_req && !o_ack;
    if (o_ack)
      last_r <= o_rdata;
    if (o_ack && i_we)
      mem[i_addr[7:0]] <= i_wdata;
  end
endmodule // sdc_mem_model
`default_nettype wire

// *** common/sdc_map.vh ***
// Register map, field positions, reset values and timing counts of the six-channel DMA
`ifndef SDC_MAP_VH
`define SDC_MAP_VH

// Channel register slots: address = {channel[2:0], slot[3:0]}
`define SDC_R_SRC        4'h0
`define SDC_R_DST        4'h1
`define SDC_R_CNT        4'h2
`define SDC_R_SFC        4'h3
`define SDC_R_MCR        4'h4
`define SDC_R_RSA        4'h5
`define SDC_R_RDA        4'h6
`define SDC_R_RCR        4'h7
`define SDC_R_RFR        4'h8
// Global block at channel field 6
`define SDC_GLOBAL_CH    3'h6
`define SDC_R_PREC       4'h0
`define SDC_R_EIDXA      4'h1
`define SDC_R_EIDXB      4'h2
`define SDC_R_FIDXA      4'h3
`define SDC_R_FIDXB      4'h4
`define SDC_R_STAT       4'h5

// Transfer mode control fields
`define SDC_MCR_ENABLE_A 15
`define SDC_MCR_INTEN    14
`define SDC_MCR_INTERRUPT_MODE_BIT     13
`define SDC_MCR_DWORD    12
`define SDC_MCR_SRCEXT   11
`define SDC_MCR_SRC_INDEX_SELECT     10:8
`define SDC_MCR_SSPC     7:6
`define SDC_MCR_DSTEXT   5
`define SDC_MCR_DEST_INDEX_SELECT     4:2
`define SDC_MCR_DMD      1:0
// Sync/frame control fields
`define SDC_SFC_SYNC     15:12
`define SDC_SFC_FRAME    7:0
// Priority/enable control fields
`define SDC_PREC_EN      5:0
`define SDC_PREC_HI      13:8
`define SDC_PREC_PER_CHANNEL_RELOAD_SELECT  15

// Index modes
`define SDC_IDX_HOLD     3'h0
`define SDC_IDX_INC      3'h1
`define SDC_IDX_DEC      3'h2
`define SDC_IDX_SETA     3'h4
`define SDC_IDX_SETB     3'h5
// Space codes and sync codes
`define SDC_SPC_PROG     2'h0
`define SDC_SPC_DATA     2'h1
`define SDC_SPC_IO       2'h2
`define SDC_SYNC_NONE    4'h0
`define SDC_SYNC_RSVD    4'hF

`define SDC_RST16        16'h0000
`define SDC_EXT_WR_MIN   4'h8
`define SDC_EXT_RD_MIN   4'hB

`endif

// *** logic/sdc_dma.v ***
// Six-channel DMA controller with register port, arbiter and memory master
// Contract
// - Six channels, each with its own transfer context, run apart from the CPU.
// - On a shared resource in the same cycle the DMA wins over the CPU.
// - Per-channel high/low priority; equal levels served round-robin.
// - Source and destination update separately: hold, inc, dec or index.
// - A channel's transfers, internal or external, may wait for a selected sync event.
// - Doubleword elements move as two 16-bit halves, addresses stepping each half.
// - Only one external-read and one external-write channel are allowed.
// - External accesses are single 16-bit words; doubleword ignored there.
// - External writes take at least 8 cycles, external reads at least 11.
// - External bus owner keeps it until done; DMA wins over CPU requests.
// - Mode bit 5 makes destination external, bit 11 the source; reset internal.
// - Destination space field: 00 program, 01 data, 10 I/O, 11 reserved.
// - DMA address decoding ignores the CPU memory map controls.
// - Enable_a reloads addresses and counts at block end and continues.
// - Reload select 0 uses channel 0 reload set, 1 each channel's own.
// - 8-bit frame counter decrements on a frame's last read; 0 is one frame.
// - 16-bit element counter decrements per element read; reloads on enable_a.
// - Index selects pick one of two element and two frame index registers.
// - Last transfer of a frame adds frame index, others the element index.
// - Channel event off unless enabled; mode picks block-only or frame plus block.
// - Sync code 0000 means none, 1111 reserved, others select event inputs.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_map.vh"

module sdc_dma #(
  parameter NCH = 6,
  parameter NEVT = 14
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_srst,
  // Register port
  input  wire [7:0]  i_reg_addr,
  input  wire [15:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output wire [15:0] o_reg_rdata,
  // Sync event pulses, bit k is event code k+1
  input  wire [NEVT-1:0] i_sync_evt,
  // Memory master
  output wire        o_mem_req,
  output wire        o_mem_we,
  output wire        o_mem_ext,
  output wire [1:0]  o_mem_space,
  output wire [15:0] o_mem_addr,
  output wire [15:0] o_mem_wdata,
  input  wire [15:0] i_mem_rdata,
  input  wire        i_mem_ack,
  // CPU arbitration
  input  wire        i_cpu_int_req,
  input  wire        i_cpu_ext_req,
  input  wire        i_cpu_ext_done,
  output wire        o_cpu_int_wait,
  output wire        o_cpu_ext_wait,
  output wire        o_cpu_ext_grant,
  // Channel events
  output wire [NCH-1:0] o_chan_evt
);

  localparam ST_IDLE = 2'd0;
  localparam ST_RD   = 2'd1;
  localparam ST_WR   = 2'd2;
  localparam OWN_FREE = 2'd0;
  localparam OWN_CPU  = 2'd1;
  localparam OWN_DMA  = 2'd2;

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function [3:0] rr_pick;
    input [5:0] m;
    input [2:0] last;
    integer k;
    integer j;
    reg     f;
    reg [2:0] idx;
    begin
      f = 1'b0;
      idx = 3'd0;
      for (k = 1; k <= 6; k = k + 1)
      begin
        j = (last + k) % 6;
        if (!f && m[j])
        begin
          f = 1'b1;
          idx = j[2:0];
        end
      end
      rr_pick = {f, idx};
    end
  endfunction

  function [15:0] step;
    input [15:0] a;
    input [2:0]  md;
    input        lst;
    input [15:0] ea;
    input [15:0] eb;
    input [15:0] fa;
    input [15:0] fb;
    begin
      case (md)
        `SDC_IDX_INC:  step = a + 16'h0001;
        `SDC_IDX_DEC:  step = a - 16'h0001;
        `SDC_IDX_SETA: step = a + (lst ? fa : ea);
        `SDC_IDX_SETB: step = a + (lst ? fb : eb);
        default:       step = a;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  reg [15:0] src_r [0:NCH-1];
  reg [15:0] dst_r [0:NCH-1];
  reg [15:0] cnt_r [0:NCH-1];
  reg [15:0] sfc_r [0:NCH-1];
  reg [15:0] mcr_r [0:NCH-1];
  reg [15:0] rsa_r [0:NCH-1];
  reg [15:0] rda_r [0:NCH-1];
  reg [15:0] rcr_r [0:NCH-1];
  reg [15:0] rfr_r [0:NCH-1];
  reg [5:0]  en_r;
  reg [5:0]  hi_r;
  reg        per_channel_reload_select_r;
  reg [15:0] eia_r, eib_r, fia_r, fib_r;
  reg [5:0]  sp_r;
  reg [1:0]  st_r;
  reg [2:0]  ch_r;
  reg [2:0]  last_hi_r, last_lo_r;
  reg        half_r;
  reg        lfrm_r, lblk_r;
  reg [1:0]  own_r;
  reg [3:0]  xcnt_r;
  reg        ack_seen_r;
  reg        req_r, we_r, ext_r;
  reg [1:0]  spc_r;
  reg [15:0] addr_r, wdata_r, rdata_r;
  reg [5:0]  evt_r;
  integer    c;

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration

  reg [5:0] xrd_ok, xwr_ok, pend;
  reg       seen_rd, seen_wr;
  integer   n;
  always @*
  begin
    xrd_ok = 6'h00;
    xwr_ok = 6'h00;
    seen_rd = 1'b0;
    seen_wr = 1'b0;
    pend = 6'h00;
    for (n = 0; n < NCH; n = n + 1)
    begin
      // Only the lowest enabled external channel of each direction may run
      if (en_r[n] && mcr_r[n][`SDC_MCR_SRCEXT] && !seen_rd)
      begin
        xrd_ok[n] = 1'b1;
        seen_rd = 1'b1;
      end
      if (en_r[n] && mcr_r[n][`SDC_MCR_DSTEXT] && !seen_wr)
      begin
        xwr_ok[n] = 1'b1;
        seen_wr = 1'b1;
      end
      pend[n] = en_r[n]
        && (sfc_r[n][`SDC_SFC_SYNC] == `SDC_SYNC_NONE || sp_r[n])
        && (!mcr_r[n][`SDC_MCR_SRCEXT] || xrd_ok[n])
        && (!mcr_r[n][`SDC_MCR_DSTEXT] || xwr_ok[n])
        && (!(mcr_r[n][`SDC_MCR_SRCEXT] || mcr_r[n][`SDC_MCR_DSTEXT])
            || own_r != OWN_CPU);
    end
  end

  wire [3:0] pick_hi = rr_pick(pend & hi_r, last_hi_r);
  wire [3:0] pick_lo = rr_pick(pend & ~hi_r, last_lo_r);
  wire       pick_f  = pick_hi[3] | pick_lo[3];
  wire [2:0] pick    = pick_hi[3] ? pick_hi[2:0] : pick_lo[2:0];
  wire       pick_x  = mcr_r[pick][`SDC_MCR_SRCEXT] | mcr_r[pick][`SDC_MCR_DSTEXT];
  wire       start   = (st_r == ST_IDLE) && pick_f;

  //////////////////////////////////////////////////////////////////////////////
  // Current channel decode

  wire [15:0] mcr   = mcr_r[ch_r];
  wire [2:0]  rset  = per_channel_reload_select_r ? ch_r : 3'd0;
  wire        dw    = mcr[`SDC_MCR_DWORD] && !ext_r;
  wire        fin   = !dw || half_r;
  wire        lfrm  = cnt_r[ch_r] == 16'h0000;
  wire        lblk  = lfrm && sfc_r[ch_r][`SDC_SFC_FRAME] == 8'h00;
  wire [3:0]  xmin  = we_r ? `SDC_EXT_WR_MIN : `SDC_EXT_RD_MIN;
  // Ack may come early; completion still waits for the external minimum
  wire        done  = (i_mem_ack || ack_seen_r)
                      && (!ext_r || xcnt_r >= xmin - 4'h1);
  wire        rd_done = (st_r == ST_RD) && done;
  wire        wr_done = (st_r == ST_WR) && done;
  wire        el_done = wr_done && fin;
  wire        dst_x   = mcr[`SDC_MCR_DSTEXT];

  //////////////////////////////////////////////////////////////////////////////
  // Engine and memory master

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st_r <= ST_IDLE;
      ch_r <= 3'd0;
      last_hi_r <= 3'd5;
      last_lo_r <= 3'd5;
      half_r <= 1'b0;
      lfrm_r <= 1'b0;
      lblk_r <= 1'b0;
      xcnt_r <= 4'h0;
      ack_seen_r <= 1'b0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      ext_r <= 1'b0;
      spc_r <= `SDC_SPC_PROG;
      addr_r <= `SDC_RST16;
      wdata_r <= `SDC_RST16;
      rdata_r <= `SDC_RST16;
    end
    else
    begin
      xcnt_r <= (st_r == ST_IDLE || done) ? 4'h0 : xcnt_r + 4'h1;
      ack_seen_r <= (st_r != ST_IDLE) && !done && (ack_seen_r || i_mem_ack);
      case (st_r)
        ST_IDLE:
        begin
          if (pick_f)
          begin
            ch_r <= pick;
            if (pick_hi[3])
              last_hi_r <= pick;
            else
              last_lo_r <= pick;
            half_r <= 1'b0;
            st_r <= ST_RD;
            req_r <= 1'b1;
            we_r <= 1'b0;
            ext_r <= mcr_r[pick][`SDC_MCR_SRCEXT];
            spc_r <= mcr_r[pick][`SDC_MCR_SSPC];
            // Addresses leave untranslated: no CPU map control reaches here
            addr_r <= src_r[pick];
          end
        end
        ST_RD:
        begin
          if (done)
          begin
            rdata_r <= i_mem_rdata;
            wdata_r <= i_mem_rdata;
            if (fin)
            begin
              lfrm_r <= lfrm;
              lblk_r <= lblk;
            end
            st_r <= ST_WR;
            we_r <= 1'b1;
            ext_r <= dst_x;
            spc_r <= mcr[`SDC_MCR_DMD];
            addr_r <= dst_r[ch_r];
          end
        end
        ST_WR:
        begin
          if (done)
          begin
            if (!fin)
            begin
              half_r <= 1'b1;
              st_r <= ST_RD;
              we_r <= 1'b0;
              ext_r <= mcr[`SDC_MCR_SRCEXT];
              spc_r <= mcr[`SDC_MCR_SSPC];
              addr_r <= src_r[ch_r];
            end
            else
            begin
              st_r <= ST_IDLE;
              req_r <= 1'b0;
              we_r <= 1'b0;
            end
          end
        end
        default:
        begin
          st_r <= ST_IDLE;
          req_r <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External bus ownership

  always @(posedge i_clk)
  begin
    if (i_srst)
      own_r <= OWN_FREE;
    else if (own_r == OWN_DMA && el_done)
      own_r <= OWN_FREE;
    else if (own_r == OWN_CPU && i_cpu_ext_done)
      own_r <= OWN_FREE;
    else if (own_r == OWN_FREE && start && pick_x)
      own_r <= OWN_DMA;
    else if (own_r == OWN_FREE && i_cpu_ext_req)
      own_r <= OWN_CPU;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel registers, counters and reload

  wire       wr_ch = i_reg_wr && i_reg_addr[6:4] < `SDC_GLOBAL_CH && !i_reg_addr[7];
  wire       wr_gl = i_reg_wr && i_reg_addr[6:4] == `SDC_GLOBAL_CH && !i_reg_addr[7];
  wire [2:0] wch   = i_reg_addr[6:4];
  wire [3:0] wsl   = i_reg_addr[3:0];

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      for (c = 0; c < NCH; c = c + 1)
      begin
        src_r[c] <= `SDC_RST16;
        dst_r[c] <= `SDC_RST16;
        cnt_r[c] <= `SDC_RST16;
        sfc_r[c] <= `SDC_RST16;
        mcr_r[c] <= `SDC_RST16;
        rsa_r[c] <= `SDC_RST16;
        rda_r[c] <= `SDC_RST16;
        rcr_r[c] <= `SDC_RST16;
        rfr_r[c] <= `SDC_RST16;
      end
      en_r <= 6'h00;
      hi_r <= 6'h00;
      per_channel_reload_select_r <= 1'b0;
      eia_r <= `SDC_RST16;
      eib_r <= `SDC_RST16;
      fia_r <= `SDC_RST16;
      fib_r <= `SDC_RST16;
    end
    else
    begin
      if (rd_done)
      begin
        src_r[ch_r] <= step(src_r[ch_r], mcr[`SDC_MCR_SRC_INDEX_SELECT], fin && lfrm,
                            eia_r, eib_r, fia_r, fib_r);
        if (fin && !lfrm)
          cnt_r[ch_r] <= cnt_r[ch_r] - 16'h0001;
        else if (fin && !lblk)
        begin
          cnt_r[ch_r] <= rcr_r[rset];
          sfc_r[ch_r][`SDC_SFC_FRAME] <= sfc_r[ch_r][`SDC_SFC_FRAME] - 8'h01;
        end
      end
      if (wr_done)
      begin
        dst_r[ch_r] <= step(dst_r[ch_r], mcr[`SDC_MCR_DEST_INDEX_SELECT], fin && lfrm_r,
                            eia_r, eib_r, fia_r, fib_r);
        if (fin && lblk_r)
        begin
          if (mcr[`SDC_MCR_ENABLE_A])
          begin
            src_r[ch_r] <= rsa_r[rset];
            dst_r[ch_r] <= rda_r[rset];
            cnt_r[ch_r] <= rcr_r[rset];
            sfc_r[ch_r][`SDC_SFC_FRAME] <= rfr_r[rset][7:0];
          end
          else
            en_r[ch_r] <= 1'b0;
        end
      end
      // A software write in the same cycle overrides the engine update
      if (wr_ch)
      begin
        if (wsl == `SDC_R_SRC)
          src_r[wch] <= i_reg_wdata;
        else if (wsl == `SDC_R_DST)
          dst_r[wch] <= i_reg_wdata;
        else if (wsl == `SDC_R_CNT)
          cnt_r[wch] <= i_reg_wdata;
        else if (wsl == `SDC_R_SFC)
          sfc_r[wch] <= i_reg_wdata;
        else if (wsl == `SDC_R_MCR)
          mcr_r[wch] <= i_reg_wdata;
        else if (wsl == `SDC_R_RSA)
          rsa_r[wch] <= i_reg_wdata;
        else if (wsl == `SDC_R_RDA)
          rda_r[wch] <= i_reg_wdata;
        else if (wsl == `SDC_R_RCR)
          rcr_r[wch] <= i_reg_wdata;
        else if (wsl == `SDC_R_RFR)
          rfr_r[wch] <= i_reg_wdata;
      end
      if (wr_gl)
      begin
        if (wsl == `SDC_R_PREC)
        begin
          en_r <= i_reg_wdata[`SDC_PREC_EN];
          hi_r <= i_reg_wdata[`SDC_PREC_HI];
          per_channel_reload_select_r <= i_reg_wdata[`SDC_PREC_PER_CHANNEL_RELOAD_SELECT];
        end
        else if (wsl == `SDC_R_EIDXA)
          eia_r <= i_reg_wdata;
        else if (wsl == `SDC_R_EIDXB)
          eib_r <= i_reg_wdata;
        else if (wsl == `SDC_R_FIDXA)
          fia_r <= i_reg_wdata;
        else if (wsl == `SDC_R_FIDXB)
          fib_r <= i_reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync latches and channel events

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sp_r <= 6'h00;
      evt_r <= 6'h00;
    end
    else
    begin
      for (c = 0; c < NCH; c = c + 1)
      begin
        evt_r[c] <= el_done && ch_r == c && mcr[`SDC_MCR_INTEN]
                    && (lblk_r || (mcr[`SDC_MCR_INTERRUPT_MODE_BIT] && lfrm_r));
        // New event wins over the clear taken at the read start
        if (sfc_r[c][`SDC_SFC_SYNC] != `SDC_SYNC_NONE
            && sfc_r[c][`SDC_SFC_SYNC] != `SDC_SYNC_RSVD
            && i_sync_evt[sfc_r[c][`SDC_SFC_SYNC] - 4'h1])
          sp_r[c] <= 1'b1;
        else if (start && pick == c)
          sp_r[c] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read

  reg [15:0] rd_r;
  always @(posedge i_clk)
  begin
    if (i_srst)
      rd_r <= `SDC_RST16;
    else if (!i_reg_rd || i_reg_addr[7])
      rd_r <= `SDC_RST16;
    else if (wch < `SDC_GLOBAL_CH)
    begin
      if (wsl == `SDC_R_SRC)
        rd_r <= src_r[wch];
      else if (wsl == `SDC_R_DST)
        rd_r <= dst_r[wch];
      else if (wsl == `SDC_R_CNT)
        rd_r <= cnt_r[wch];
      else if (wsl == `SDC_R_SFC)
        rd_r <= sfc_r[wch];
      else if (wsl == `SDC_R_MCR)
        rd_r <= mcr_r[wch];
      else if (wsl == `SDC_R_RSA)
        rd_r <= rsa_r[wch];
      else if (wsl == `SDC_R_RDA)
        rd_r <= rda_r[wch];
      else if (wsl == `SDC_R_RCR)
        rd_r <= rcr_r[wch];
      else if (wsl == `SDC_R_RFR)
        rd_r <= rfr_r[wch];
      else
        rd_r <= `SDC_RST16;
    end
    else if (wch == `SDC_GLOBAL_CH)
    begin
      if (wsl == `SDC_R_PREC)
        rd_r <= {per_channel_reload_select_r, 1'b0, hi_r, 2'b00, en_r};
      else if (wsl == `SDC_R_EIDXA)
        rd_r <= eia_r;
      else if (wsl == `SDC_R_EIDXB)
        rd_r <= eib_r;
      else if (wsl == `SDC_R_FIDXA)
        rd_r <= fia_r;
      else if (wsl == `SDC_R_FIDXB)
        rd_r <= fib_r;
      else if (wsl == `SDC_R_STAT)
        rd_r <= {st_r != ST_IDLE, own_r, half_r, 2'b00, sp_r, 1'b0, ch_r};
      else
        rd_r <= `SDC_RST16;
    end
    else
      rd_r <= `SDC_RST16;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_reg_rdata     = rd_r;
  assign o_mem_req       = req_r;
  assign o_mem_we        = we_r;
  assign o_mem_ext       = ext_r;
  assign o_mem_space     = spc_r;
  assign o_mem_addr      = addr_r;
  assign o_mem_wdata     = wdata_r;
  assign o_cpu_int_wait  = i_cpu_int_req && req_r && !ext_r;
  assign o_cpu_ext_wait  = i_cpu_ext_req && own_r != OWN_CPU;
  assign o_cpu_ext_grant = own_r == OWN_CPU;
  assign o_chan_evt      = evt_r;

endmodule // sdc_dma
`default_nettype wire
